// *** verilog/psu_status_sequencer.sv ***
// Supervisory sequencer of a front-end supply: output enables, line-ok, front indicators.
// Assumes all seven status inputs are asynchronous pins; the far controller drives main_on_n and unplug_kill_in.
// Behaviour
// [R01] No line power: green and amber indicators both off; the indicators go dark only once standby_enable has also dropped.
// [R02] Supply failure: amber steady on, green off.
// [R03] Warning while operating: amber blinks, green off.
// [R04] Line present, standby up, main off: green blinks, amber off.
// [R05] All outputs on and regulated: green steady, amber off.
// [R06] Drive inserted_n low once the supply is fully seated.
// [R07] Unplug-kill is active high and drops the main output at once.
// [R08] Standby output stays enabled regardless of unplug-kill.
// [R09] Outputs start by themselves on valid line with main_on_n low.
// [R10] First start: line_ok_out rises within 2000 ms of valid line.
// [R11] After a dip: line_ok_out rises within 100 ms of line return.
// [R12] Line lost: line_ok_out falls within 5 ms.
// [R13] Main output stays off 1 to 2 s before it may restart.
// [R14] Outage under 10 ms is a short dip, 10 to 100 ms a long dip.
// [R15] Main output stays enabled at least 10 ms after line loss.
// [R16] main_on_n low enables main; toggling it clears latched faults.
// [R17] Failure outranks warning, warning outranks the green states.
// [R18] Indicator blink is about 1 Hz, 50 percent duty, from the clock.
`timescale 1ns/1ps
module psu_status_sequencer
#(
   parameter int TICK_CYCLES = psu_seq_pkg::CYCLES_PER_MS
)
(
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic line_valid,
   input  wire logic main_on_n,
   input  wire logic unplug_kill_in,
   input  wire logic seated,
   input  wire logic fail_in,
   input  wire logic warn_in,
   input  wire logic main_good,
   output logic      main_output,
   output logic      standby_enable,
   output logic      line_ok_out,
   output logic      led_green,
   output logic      led_amber,
   output logic      inserted_n,
   output logic      dip_short,
   output logic      dip_long
);
   localparam int MS_W = psu_seq_pkg::MS_W;

   function automatic logic [11:0] sat_inc(input logic [11:0] v);
      sat_inc = (v == 12'hFFF) ? v : v + 12'h001;
   endfunction

   logic [psu_seq_pkg::IN_W-1:0] sync1;
   logic [psu_seq_pkg::IN_W-1:0] sync2;
   logic [psu_seq_pkg::IN_W-1:0] sync3;
   logic [psu_seq_pkg::IN_W-1:0] filt;
   logic [14:0]                  tick_cnt;
   logic                         tick;
   logic [MS_W-1:0]              on_ms;
   logic [MS_W-1:0]              outage_ms;
   logic [MS_W-1:0]              off_ms;
   logic [MS_W-1:0]              blink_ms;
   logic                         blink;
   logic                         ever_up;
   logic                         fault_latched;
   logic                         main_on_n_q;
   psu_seq_pkg::main_state_e     state;
   psu_seq_pkg::main_state_e     next_state;

   wire [psu_seq_pkg::IN_W-1:0] raw = {main_good, warn_in, fail_in, seated, unplug_kill_in, main_on_n, line_valid};
   wire [psu_seq_pkg::IN_W-1:0] disagree = sync2 ^ sync3;
   wire [psu_seq_pkg::IN_W-1:0] next_filt = (sync3 & ~disagree) | (filt & disagree);

   wire line_s   = filt[psu_seq_pkg::IN_LINE];
   wire on_n_s   = filt[psu_seq_pkg::IN_MAIN_ON_N];
   wire kill_s   = filt[psu_seq_pkg::IN_KILL];
   wire seated_s = filt[psu_seq_pkg::IN_SEATED];
   wire fail_s   = filt[psu_seq_pkg::IN_FAIL];
   wire warn_s   = filt[psu_seq_pkg::IN_WARN];
   wire good_s   = filt[psu_seq_pkg::IN_MAIN_GOOD];

   // Any edge of main_on_n counts as a toggle
   wire on_n_toggle = on_n_s ^ main_on_n_q; // [R16]
   wire fault_now   = fail_s | fault_latched;
   wire line_gone   = !line_s && outage_ms > psu_seq_pkg::MAIN_HOLDUP_MS; // [R15]
   wire main_stop   = kill_s | on_n_s | fault_now | line_gone; // [R07] [R16]
   wire main_start  = line_s & line_ok_out & !on_n_s & !kill_s & !fault_now; // [R09]
   wire ok_delay_ok = on_ms >= (ever_up ? psu_seq_pkg::LINE_OK_DIP_MS : psu_seq_pkg::LINE_OK_START_MS); // [R10] [R11]
   wire line_drop   = !line_s && outage_ms >= psu_seq_pkg::LINE_OK_OFF_MS; // [R12]
   wire line_return = line_s && outage_ms != 12'h000;
   wire sb_on       = line_s || outage_ms < psu_seq_pkg::SB_HOLDUP_MS; // [R08]

   // Indicator selection, highest priority first
   wire no_power    = !line_s && !standby_enable; // [R01]
   wire next_amber  = no_power ? 1'b0 : fault_now ? 1'b1 : warn_s ? blink : 1'b0; // [R02] [R03] [R17]
   wire next_green  = (no_power || fault_now || warn_s) ? 1'b0 : // [R17]
                      (main_output && good_s) ? 1'b1 : // [R05]
                      standby_enable ? blink : 1'b0; // [R04]

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         sync1 <= psu_seq_pkg::IN_RESET;
         sync2 <= psu_seq_pkg::IN_RESET;
         sync3 <= psu_seq_pkg::IN_RESET;
         filt  <= psu_seq_pkg::IN_RESET;
      end
      else
      begin
         sync1 <= raw;
         sync2 <= sync1;
         sync3 <= sync2;
         filt  <= next_filt;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst || tick)
         tick_cnt <= 15'h0000;
      else
         tick_cnt <= tick_cnt + 15'h0001;
   end
   assign tick = (tick_cnt == 15'(TICK_CYCLES - 1));

   // Millisecond counters saturate so a long outage never wraps into a short one
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         on_ms     <= 12'h000;
         outage_ms <= 12'hFFF; // Saturated: no standby hold-up before any line
      end
      else if (line_s)
      begin
         outage_ms <= 12'h000;
         if (tick)
            on_ms <= sat_inc(on_ms);
      end
      else
      begin
         on_ms <= 12'h000;
         if (tick)
            outage_ms <= sat_inc(outage_ms);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         dip_short <= 1'b0;
         dip_long  <= 1'b0;
      end
      else
      begin
         dip_short <= line_return && ever_up && outage_ms < psu_seq_pkg::SHORT_DIP_MS; // [R14]
         dip_long  <= line_return && ever_up && outage_ms >= psu_seq_pkg::SHORT_DIP_MS
                      && outage_ms <= psu_seq_pkg::LONG_DIP_MS; // [R14]
      end
   end

   // A loss beyond a long dip counts as a fresh start-up
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         ever_up <= 1'b0;
      else if (line_ok_out)
         ever_up <= 1'b1;
      else if (!line_s && outage_ms > psu_seq_pkg::LONG_DIP_MS)
         ever_up <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         line_ok_out <= 1'b0;
      else if (line_drop)
         line_ok_out <= 1'b0; // [R12]
      else if (line_s && ok_delay_ok)
         line_ok_out <= 1'b1; // [R10] [R11]
   end

   // Fault set wins over a clear in the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         fault_latched <= 1'b0;
         main_on_n_q   <= 1'b1;
      end
      else
      begin
         main_on_n_q   <= on_n_s;
         fault_latched <= fail_s | (fault_latched & !on_n_toggle); // [R16]
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         psu_seq_pkg::ST_READY: if (main_start) next_state = psu_seq_pkg::ST_ON; // [R09]
         psu_seq_pkg::ST_ON:    if (main_stop) next_state = psu_seq_pkg::ST_HOLD; // [R07]
         psu_seq_pkg::ST_HOLD:  if (off_ms >= psu_seq_pkg::MIN_OFF_MS) next_state = psu_seq_pkg::ST_READY; // [R13]
         default:               next_state = psu_seq_pkg::ST_READY;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state       <= psu_seq_pkg::ST_READY;
         main_output <= 1'b0;
         off_ms      <= 12'h000;
      end
      else
      begin
         state       <= next_state;
         main_output <= (next_state == psu_seq_pkg::ST_ON); // [R07] [R13]
         if (state != psu_seq_pkg::ST_HOLD)
            off_ms <= 12'h000;
         else if (tick)
            off_ms <= sat_inc(off_ms); // [R13]
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         blink_ms <= 12'h000;
         blink    <= 1'b0;
      end
      else if (tick)
      begin
         if (blink_ms == psu_seq_pkg::BLINK_HALF_MS - 12'h001)
         begin
            blink_ms <= 12'h000;
            blink    <= !blink; // [R18]
         end
         else
            blink_ms <= blink_ms + 12'h001;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         standby_enable <= 1'b0;
         led_green      <= 1'b0;
         led_amber      <= 1'b0;
         inserted_n     <= 1'b1;
      end
      else
      begin
         standby_enable <= sb_on; // [R08]
         led_green      <= next_green;
         led_amber      <= next_amber;
         inserted_n     <= !seated_s; // [R06]
      end
   end

   sequence kill_seen;
      kill_s && state == psu_seq_pkg::ST_ON;
   endsequence
   sequence main_dropped;
      !main_output ##1 !main_output;
   endsequence

   AST_KILL_DROPS_MAIN: assert property (@(posedge ref_clk) disable iff (srst) // [R07]
      kill_seen |-> ##1 main_dropped) else $error("main output survived unplug kill");
   AST_STANDBY_IGNORES_KILL: assert property (@(posedge ref_clk) disable iff (srst) // [R08]
      line_s && $rose(kill_s) |-> ##1 standby_enable) else $error("standby dropped by kill");
   AST_LINE_OK_FALLS: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
      line_drop |=> !line_ok_out) else $error("line ok still high after line loss");
   AST_LINE_OK_RISES: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
      line_s && on_ms >= psu_seq_pkg::LINE_OK_START_MS |=> line_ok_out) else $error("line ok late");
   AST_HOLDUP: assert property (@(posedge ref_clk) disable iff (srst) // [R15]
      main_output && !line_s && outage_ms < psu_seq_pkg::MAIN_HOLDUP_MS && !kill_s && !on_n_s && !fault_now
      |=> main_output) else $error("main output dropped inside holdup");
   AST_MIN_OFF: assert property (@(posedge ref_clk) disable iff (srst) // [R13]
      $fell(main_output) |-> !main_output throughout (state == psu_seq_pkg::ST_HOLD)[*8])
      else $error("main output restarted early");
   AST_HOLD_EXIT: assert property (@(posedge ref_clk) disable iff (srst) // [R13]
      state == psu_seq_pkg::ST_HOLD && off_ms < psu_seq_pkg::MIN_OFF_MS |=> state != psu_seq_pkg::ST_ON)
      else $error("hold left too early");
   AST_NO_POWER_DARK: assert property (@(posedge ref_clk) disable iff (srst) // [R01]
      no_power |=> !led_green && !led_amber) else $error("indicator lit without power");
   AST_FAIL_AMBER: assert property (@(posedge ref_clk) disable iff (srst) // [R02]
      !no_power && fault_now |=> led_amber && !led_green) else $error("failure not shown amber");
   AST_FAULT_STICKY: assert property (@(posedge ref_clk) disable iff (srst) // [R16]
      fault_latched && !on_n_toggle |=> fault_latched) else $error("fault cleared without toggle");
   AST_INSERTED: assert property (@(posedge ref_clk) disable iff (srst) // [R06]
      seated_s |=> !inserted_n) else $error("inserted not driven low");
endmodule

// *** verilog/psu_seq_pkg.sv ***
// Constants for the supply status sequencer: input layout, reset levels, timing.
// Assumes one 25 MHz clock; all supervisory timing runs on a 1 ms tick.
package psu_seq_pkg;
   localparam int          CLK_HZ          = 25_000_000;
   localparam int          MS_PER_S        = 1000;
   localparam int          CYCLES_PER_MS   = CLK_HZ / MS_PER_S;
   localparam int          MS_W            = 12;
   localparam int          IN_W            = 7;

   // Positions in the synchronised input vector
   localparam int          IN_LINE         = 0;
   localparam int          IN_MAIN_ON_N    = 1;
   localparam int          IN_KILL         = 2;
   localparam int          IN_SEATED       = 3;
   localparam int          IN_FAIL         = 4;
   localparam int          IN_WARN         = 5;
   localparam int          IN_MAIN_GOOD    = 6;
   // Pulled-up pins read high until the filter has seen them
   localparam logic [6:0]  IN_RESET        = 7'h06;

   // Times in ms
   localparam logic [11:0] LINE_OK_START_MS = 12'h3E8; // 1000, inside the 2000 ms limit
   localparam logic [11:0] LINE_OK_DIP_MS   = 12'h032; // 50, inside the 100 ms limit
   localparam logic [11:0] LINE_OK_OFF_MS   = 12'h002; // 2, inside the 5 ms limit
   localparam logic [11:0] MAIN_HOLDUP_MS   = 12'h00A; // 10
   localparam logic [11:0] SB_HOLDUP_MS     = 12'h014; // 20
   localparam logic [11:0] SHORT_DIP_MS     = 12'h00A; // 10
   localparam logic [11:0] LONG_DIP_MS      = 12'h064; // 100
   localparam logic [11:0] MIN_OFF_MS       = 12'h5DC; // 1500, between 1 s and 2 s
   localparam logic [11:0] BLINK_HALF_MS    = 12'h1F4; // 500, 1 Hz at 50 percent

   typedef enum {ST_READY, ST_ON, ST_HOLD} main_state_e;
endpackage

// *** test/pdu_ctrl_model.sv ***
// Behavioural system controller driving the supply's control pins.
// Assumes requests from the bench change just after a rising edge of ref_clk.
`timescale 1ns/1ps
module pdu_ctrl_model
#(
   parameter int HI_MIN = 100
)
(
   input  wire logic ref_clk,
   input  wire logic want_on,
   input  wire logic want_kill,
   output logic      main_on_n,
   output logic      unplug_kill_in
);
   int hi_cycles = 0;
   initial main_on_n = 1'b1;
   initial unplug_kill_in = 1'b0;
   // Enable pin must stay high a minimum time before it may drop again
   always @(posedge ref_clk)
   begin
      hi_cycles <= main_on_n ? hi_cycles + 1 : 0;
      if (!want_on)
         main_on_n <= 1'b1;
      else if (!main_on_n || hi_cycles >= HI_MIN)
         main_on_n <= 1'b0;
      unplug_kill_in <= want_kill;
   end
endmodule

// *** test/tb_psu_status_sequencer.sv ***
// Self-checking bench for the supply status sequencer with a controller model.
// Assumes a 10-clock ms tick so every ms figure scales down.
`timescale 1ns/1ps
module tb_psu_status_sequencer;
   localparam int TICK = 10;
   localparam int O_MAIN = 0, O_LOK = 2, O_GRN = 3, O_AMB = 4, O_INS = 5, O_DS = 6, O_DL = 7;
   logic ref_clk = 1'b0, srst = 1'b1, line_valid = 1'b0, want_on = 1'b0, want_kill = 1'b0;
   logic seated = 1'b0, fail_in = 1'b0, warn_in = 1'b0, main_good = 1'b0;
   logic main_on_n, unplug_kill_in, main_output, standby_enable, line_ok_out;
   logic led_green, led_amber, inserted_n, dip_short, dip_long;
   int   errors = 0, num_checks = 0, n;
   wire logic [7:0] obs = {dip_long, dip_short, inserted_n, led_amber, led_green,
                           line_ok_out, standby_enable, main_output};

   always #20 ref_clk = ~ref_clk;

   pdu_ctrl_model #(.HI_MIN(10 * TICK)) pdu_ctrl_model_inst (.ref_clk(ref_clk), .want_on(want_on),
      .want_kill(want_kill), .main_on_n(main_on_n), .unplug_kill_in(unplug_kill_in));

   psu_status_sequencer #(.TICK_CYCLES(TICK)) psu_status_sequencer_inst (.ref_clk(ref_clk),
      .srst(srst), .line_valid(line_valid), .main_on_n(main_on_n), .unplug_kill_in(unplug_kill_in),
      .seated(seated), .fail_in(fail_in), .warn_in(warn_in), .main_good(main_good),
      .main_output(main_output), .standby_enable(standby_enable), .line_ok_out(line_ok_out),
      .led_green(led_green), .led_amber(led_amber), .inserted_n(inserted_n),
      .dip_short(dip_short), .dip_long(dip_long));

   task automatic step(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %b seen %b", nm, exp, seen);
      end
   endtask

   task automatic finish_test;
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // A missed wait ends the run; later scenarios would only cascade
   task automatic wait_obs(input string nm, input int idx, input logic v, input int ms);
      for (int i = 0; i < ms * TICK && obs[idx] !== v; i++)
         step(1);
      chk(nm, obs[idx], v);
      if (obs[idx] !== v)
         finish_test;
   endtask

   task automatic hi_ms(input int idx, input int ms, output int c);
      c = 0;
      repeat (ms * TICK)
      begin
         step(1);
         c += (obs[idx] === 1'b1);
      end
   endtask

   // Blink judged over one second: half on, small slack for tick phase
   task automatic duty(input string nm, input int idx);
      hi_ms(idx, 1000, n);
      chk(nm, n >= 490 * TICK && n <= 510 * TICK, 1'b1);
   endtask

   task automatic t_reset;
      step(12);
      srst = 1'b0;
      step(50);
      chk("main_output", main_output, 1'b0);
      chk("standby_enable", standby_enable, 1'b0);
      chk("led_green", led_green, 1'b0);
      chk("led_amber", led_amber, 1'b0);
      seated = 1'b1;
      wait_obs("inserted_n", O_INS, 1'b0, 1);
   endtask

   task automatic t_start;
      want_on = 1'b1;
      line_valid = 1'b1;
      wait_obs("line_ok_out", O_LOK, 1'b1, 2000);
      wait_obs("main_output", O_MAIN, 1'b1, 1);
      chk("standby_enable", standby_enable, 1'b1);
      main_good = 1'b1;
      step(10);
      chk("led_green", led_green, 1'b1);
      chk("led_amber", led_amber, 1'b0);
   endtask

   task automatic t_kill;
      want_kill = 1'b1;
      wait_obs("main_output", O_MAIN, 1'b0, 1);
      chk("standby_enable", standby_enable, 1'b1);
      duty("green blink", O_GRN);
      chk("led_amber", led_amber, 1'b0);
      want_kill = 1'b0;
      hi_ms(O_MAIN, 400, n);
      chk("main held off", n == 0, 1'b1);
      wait_obs("main restart", O_MAIN, 1'b1, 600);
      step(10);
   endtask

   task automatic t_fault;
      fail_in = 1'b1;
      warn_in = 1'b1;
      step(20);
      chk("main_output", main_output, 1'b0);
      hi_ms(O_AMB, 100, n);
      chk("amber steady", n == 100 * TICK, 1'b1);
      chk("led_green", led_green, 1'b0);
      fail_in = 1'b0;
      step(20);
      chk("amber latched", led_amber, 1'b1);
      want_on = 1'b0;
      step(20 * TICK);
      want_on = 1'b1;
      step(20 * TICK);
      duty("amber blink", O_AMB);
      chk("led_green", led_green, 1'b0);
      warn_in = 1'b0;
      wait_obs("main restart", O_MAIN, 1'b1, 2000);
      step(10);
   endtask

   task automatic t_dips;
      line_valid = 1'b0;
      step(5 * TICK);
      chk("line_ok_out", line_ok_out, 1'b0);
      step(3 * TICK);
      chk("main holdup", main_output, 1'b1);
      line_valid = 1'b1;
      wait_obs("dip_short", O_DS, 1'b1, 1);
      chk("dip_long", dip_long, 1'b0);
      wait_obs("line_ok_out", O_LOK, 1'b1, 100);
      line_valid = 1'b0;
      step(30 * TICK);
      line_valid = 1'b1;
      wait_obs("dip_long", O_DL, 1'b1, 1);
      chk("dip_short", dip_short, 1'b0);
      wait_obs("line_ok_out", O_LOK, 1'b1, 100);
      line_valid = 1'b0;
      step(40 * TICK);
      chk("led_green", led_green, 1'b0);
      chk("led_amber", led_amber, 1'b0);
   endtask

   initial
   begin
      t_reset;
      t_start;
      t_kill;
      t_fault;
      t_dips;
      finish_test;
   end
endmodule
